// ---- rtl/dpc_params.svh ----
// Register offsets, field positions, reset values and codes of the parameter channel.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

`define DPC_OFF_CFG       12'h000
`define DPC_OFF_REQ_ADDR  12'h004
`define DPC_OFF_REQ_KEY   12'h008
`define DPC_OFF_REQ_VAL   12'h00C
`define DPC_OFF_REQ_PCD   12'h010
`define DPC_OFF_GO        12'h014
`define DPC_OFF_RSP_KEY   12'h018
`define DPC_OFF_RSP_VAL   12'h01C
`define DPC_OFF_RSP_PCD   12'h020
`define DPC_OFF_RSP_ADDR  12'h024
`define DPC_OFF_TYPE_SEL  12'h028
`define DPC_OFF_MEM_BASE  12'h100

`define DPC_CFG_ALT       0
`define DPC_CFG_ADDR_LSB  1
`define DPC_CFG_BAUD_LSB  9
`define DPC_CFG_PAR_LSB   12
`define DPC_CFG_STOP2     14

`define DPC_RST_ADDR      8'h01
`define DPC_RST_BAUD      3'h2
`define DPC_RST_PARITY    2'h0
`define DPC_ADDR_MAX_FC   8'h7E
`define DPC_ADDR_MAX_ALT  8'hF7

`define DPC_CMD_NONE      4'h0
`define DPC_CMD_READ      4'h1
`define DPC_CMD_WR_W      4'h2
`define DPC_CMD_WR_D      4'h3
`define DPC_CMD_WR_D_NV   4'hD
`define DPC_CMD_WR_W_NV   4'hE
`define DPC_CMD_TEXT      4'hF

`define DPC_RSP_NONE      4'h0
`define DPC_RSP_WORD      4'h1
`define DPC_RSP_DWORD     4'h2
`define DPC_RSP_ERR       4'h7
`define DPC_RSP_TEXT      4'hF

`define DPC_TXT_READ      8'h04
`define DPC_TXT_WRITE     8'h05
`define DPC_TXT_LEN       8'h0E

`define DPC_FLT_NO_PNU    16'h0000
`define DPC_FLT_SUBIDX    16'h0003
`define DPC_FLT_TYPE      16'h0005

`define DPC_TY_I16        6'h03
`define DPC_TY_I32        6'h04
`define DPC_TY_U8         6'h05
`define DPC_TY_U16        6'h06
`define DPC_TY_U32        6'h07
`define DPC_TY_TEXT       6'h09
`define DPC_TY_BYTES      6'h0A
`define DPC_TY_TDIFF      6'h0D
`define DPC_TY_RSVD       6'h21
`define DPC_TY_BITS       6'h23

`define DPC_CW_START      0
`define DPC_CW_COAST      1
`define DPC_CW_QUICK      2
`define DPC_CW_DCBRAKE    3
`define DPC_CW_RAMP       4
`define DPC_CW_FRESET     5
`define DPC_CW_PRESET_LSB 6
`define DPC_CW_REVERSE    8
`define DPC_CW_SETUP_LSB  9
`define DPC_CW_RELAY      11

`endif

// ---- rtl/dpc_pkg.sv ----
// Types shared by the parameter channel interpreter.
`default_nettype none
package dpc_pkg;

	typedef enum logic [1:0] {
		DPC_IDLE = 2'b00,
		DPC_READ = 2'b01,
		DPC_EXEC = 2'b10
	} dpc_state_t;

	typedef enum logic [1:0] {
		DPC_SZ_BAD   = 2'b00,
		DPC_SZ_WORD  = 2'b01,
		DPC_SZ_DWORD = 2'b10,
		DPC_SZ_TEXT  = 2'b11
	} dpc_size_t;

	typedef struct packed {
		dpc_state_t  state;
		logic        cfg_alt;
		logic [7:0]  cfg_addr;
		logic [2:0]  cfg_baud;
		logic [1:0]  cfg_par;
		logic        cfg_stop2;
		logic [7:0]  req_addr;
		logic [7:0]  req_len;
		logic [15:0] req_key;
		logic [15:0] req_idx;
		logic [31:0] req_val;
		logic [15:0] req_cw;
		logic [15:0] req_ref;
		logic [5:0]  type_sel;
		logic        bcast;
		logic [15:0] rsp_key;
		logic [15:0] rsp_idx;
		logic [31:0] rsp_val;
		logic [15:0] rsp_pcd1;
		logic [15:0] rsp_pcd2;
		logic [7:0]  rsp_addr;
		logic [7:0]  rsp_len;
		logic        rsp_rdy;
		logic        rsp_err;
		logic        rsp_bcast;
		logic        rsp_miss;
		logic [15:0] ctl_word;
		logic [15:0] ref_word;
		logic        nvm_wr;
		logic [11:0] nvm_pnu;
		logic [31:0] prdata;
		logic        pslverr;
	} dpc_st_t;

endpackage : dpc_pkg
`default_nettype wire

// ---- rtl/dpc_pmem.sv ----
// Parameter store: one write port, one read port with registered data.
`default_nettype none
module dpc_pmem #(
	parameter int W     = 38,
	parameter int DEPTH = 64,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock.
	input  wire logic          clock,
	// Write port.
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read port.
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem [DEPTH];

	// No reset on the array so that it maps onto block memory.
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : dpc_pmem
`default_nettype wire

// ---- rtl/dpc_top.sv ----
// Parameter channel and process word interpreter with an APB register file.
//
// Contract
// - value field is two words, meaning per command
// - read answer carries present parameter value
// - text reads only for type 9
// - text telegram length given in length byte
// - decode data type codes to sizes
// - values carried only as whole integers
// - real value is integer times factor
// - two process words in fixed order
// - control/reference in, status/frequency out
// - command E writes word to RAM and storage
// - device never starts a transaction
// - broadcast acted on, never answered
// - faulty or impossible query gets error answer
// - answer confirms action, data, check field
// - protocol select, address 1-247, baud select; without cfg_alt the code takes only 1-126
// - default even parity, one stop bit
// - control word drives start, stops, reset, etc
// - key bits 15-12 command, 11-0 number
// - failure returns 0111 and fault code low
// - index low byte is array index only
`include "dpc_params.svh"
`default_nettype none
module dpc_top #(
	parameter int DEPTH = 64
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_b,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Drive state returned in the answer.
	input  wire logic [15:0] status_word,
	input  wire logic [15:0] out_freq,
	// Line settings for the framing logic.
	output logic             proto_alt,
	output logic      [2:0]  baud_sel,
	output logic      [1:0]  parity_sel,
	output logic             two_stop,
	// Received control word and reference.
	output logic             cw_start,
	output logic             cw_coast_stop,
	output logic             cw_quick_stop,
	output logic             cw_dc_brake,
	output logic             cw_ramp_stop,
	output logic             cw_fault_reset,
	output logic      [1:0]  cw_preset,
	output logic             cw_reverse,
	output logic      [1:0]  cw_setup,
	output logic             cw_relay,
	output logic      [15:0] ref_word,
	// Non-volatile store request.
	output logic             nvm_wr,
	output logic      [11:0] nvm_pnu,
	output logic      [31:0] nvm_data
);
	import dpc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int MW = 38;

	dpc_st_t     s;
	dpc_st_t     n;
	logic [1:0]  rst_sync;
	logic        rst_n_int;
	logic        mem_we;
	logic [AW-1:0] mem_waddr;
	logic [MW-1:0] mem_wdata;
	logic [MW-1:0] mem_rdata;

	// Size class of each data type code; unknown and reserved are refused.
	function automatic dpc_size_t dpc_type_size(input logic [5:0] ty);
		case (ty)
			`DPC_TY_I16, `DPC_TY_U8, `DPC_TY_U16,
			`DPC_TY_BITS:  dpc_type_size = DPC_SZ_WORD;
			`DPC_TY_I32, `DPC_TY_U32, `DPC_TY_BYTES,
			`DPC_TY_TDIFF: dpc_type_size = DPC_SZ_DWORD;
			`DPC_TY_TEXT:  dpc_type_size = DPC_SZ_TEXT;
			default:       dpc_type_size = DPC_SZ_BAD;
		endcase
	endfunction : dpc_type_size

	// Address match: bit 1 broadcast, bit 0 addressed to this slave.
	function automatic logic [1:0] dpc_addr_hit(input logic alt,
		input logic [7:0] a, input logic [7:0] own);
		if (alt) begin
			dpc_addr_hit = {a == 8'h00, a == own};
		end else if (a[7]) begin
			dpc_addr_hit = {a[6:0] == 7'h00, a[6:0] == own[6:0]};
		end else begin
			dpc_addr_hit = {a[5], !a[5] && a[4:0] == own[4:0]};
		end
	endfunction : dpc_addr_hit

	dpc_pmem #(
		.W     (MW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_pmem (
		.clock (clock),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (s.req_key[AW-1:0]),
		.rdata (mem_rdata)
	);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync[1];

	always_comb begin
		logic        acc_wr;
		logic        busy;
		logic [1:0]  hit;
		logic [3:0]  cmd;
		logic [11:0] param_number;
		dpc_size_t   tsz;
		logic        err;
		logic        wr;
		logic        nv;
		logic [15:0] fault;
		logic [3:0]  rcode;
		logic [31:0] rval;
		logic [31:0] wval;
		logic [7:0]  na;
		n         = s;
		acc_wr    = psel && penable && pwrite;
		busy      = s.state != DPC_IDLE;
		hit       = dpc_addr_hit(s.cfg_alt, s.req_addr, s.cfg_addr);
		cmd       = s.req_key[15:12];
		param_number       = s.req_key[11:0];
		tsz       = dpc_type_size(mem_rdata[37:32]);
		err       = 1'b0;
		wr        = 1'b0;
		nv        = 1'b0;
		fault     = `DPC_FLT_TYPE;
		rcode     = `DPC_RSP_NONE;
		rval      = 32'h0000_0000;
		wval      = s.req_val;
		na        = pwdata[8:1];
		mem_we    = 1'b0;
		mem_waddr = paddr[AW+1:2];
		mem_wdata = {s.type_sel, pwdata};
		n.nvm_wr  = 1'b0;

		// Register writes take effect at the access edge.
		if (acc_wr) begin
			case (paddr)
				`DPC_OFF_CFG: begin
					n.cfg_alt   = pwdata[`DPC_CFG_ALT];
					n.cfg_baud  = pwdata[`DPC_CFG_BAUD_LSB +: 3];
					n.cfg_par   = pwdata[`DPC_CFG_PAR_LSB +: 2];
					n.cfg_stop2 = pwdata[`DPC_CFG_STOP2];
					// An out-of-range address is dropped, old one kept.
					if (na != 8'h00 && na <= (pwdata[`DPC_CFG_ALT] ?
						`DPC_ADDR_MAX_ALT : `DPC_ADDR_MAX_FC)) begin
						n.cfg_addr = na;
					end
				end
				`DPC_OFF_TYPE_SEL: n.type_sel = pwdata[5:0];
				`DPC_OFF_GO: begin
					if (pwdata[1]) begin
						n.rsp_rdy = 1'b0;
					end
				end
				default: begin
				end
			endcase
			// The request fields are frozen while a request executes.
			if (!busy) begin
				case (paddr)
					`DPC_OFF_REQ_ADDR: begin
						n.req_addr = pwdata[7:0];
						n.req_len  = pwdata[15:8];
					end
					`DPC_OFF_REQ_KEY: begin
						n.req_key = pwdata[15:0];
						n.req_idx = pwdata[31:16];
					end
					`DPC_OFF_REQ_VAL: n.req_val = pwdata;
					`DPC_OFF_REQ_PCD: begin
						n.req_cw  = pwdata[15:0];
						n.req_ref = pwdata[31:16];
					end
					`DPC_OFF_GO: begin
						if (pwdata[0]) begin
							n.state = DPC_READ;
						end
					end
					default: begin
					end
				endcase
			end
			if (paddr[11:8] == 4'h1 && int'(paddr[7:2]) < DEPTH &&
				s.state != DPC_EXEC) begin
				mem_we = 1'b1;
			end
		end

		case (s.state)
			DPC_IDLE: begin
			end
			DPC_READ: begin
				// Parameter data becomes valid one edge after the key.
				if (hit == 2'b00) begin
					n.rsp_miss = 1'b1;
					n.state    = DPC_IDLE;
				end else begin
					n.rsp_miss = 1'b0;
					n.bcast    = hit[1];
					n.state    = DPC_EXEC;
				end
			end
			DPC_EXEC: begin
				if (32'(param_number) >= DEPTH) begin
					err   = 1'b1;
					fault = `DPC_FLT_NO_PNU;
				end else begin
					case (cmd)
						`DPC_CMD_NONE: rcode = `DPC_RSP_NONE;
						`DPC_CMD_READ: begin
							if (s.req_idx[7:0] != 8'h00) begin
								err   = 1'b1;
								fault = `DPC_FLT_SUBIDX;
							end else if (tsz == DPC_SZ_WORD) begin
								rcode = `DPC_RSP_WORD;
								rval  = {16'h0000, mem_rdata[15:0]};
							end else if (tsz == DPC_SZ_DWORD) begin
								rcode = `DPC_RSP_DWORD;
								rval  = mem_rdata[31:0];
							end else begin
								err = 1'b1;
							end
						end
						`DPC_CMD_WR_W, `DPC_CMD_WR_W_NV: begin
							if (s.req_idx[7:0] != 8'h00) begin
								err   = 1'b1;
								fault = `DPC_FLT_SUBIDX;
							end else if (tsz != DPC_SZ_WORD) begin
								err = 1'b1;
							end else begin
								wr    = 1'b1;
								nv    = cmd == `DPC_CMD_WR_W_NV;
								wval  = {16'h0000, s.req_val[15:0]};
								rcode = `DPC_RSP_WORD;
								rval  = wval;
							end
						end
						`DPC_CMD_WR_D, `DPC_CMD_WR_D_NV: begin
							if (s.req_idx[7:0] != 8'h00) begin
								err   = 1'b1;
								fault = `DPC_FLT_SUBIDX;
							end else if (tsz != DPC_SZ_DWORD) begin
								err = 1'b1;
							end else begin
								wr    = 1'b1;
								nv    = cmd == `DPC_CMD_WR_D_NV;
								rcode = `DPC_RSP_DWORD;
								rval  = wval;
							end
						end
						`DPC_CMD_TEXT: begin
							if (tsz != DPC_SZ_TEXT) begin
								err = 1'b1;
							end else if (s.req_idx[15:8] ==
								`DPC_TXT_READ) begin
								rcode = `DPC_RSP_TEXT;
								rval  = mem_rdata[31:0];
							end else if (s.req_idx[15:8] ==
								`DPC_TXT_WRITE) begin
								wr    = 1'b1;
								rcode = `DPC_RSP_TEXT;
								rval  = wval;
							end else begin
								err = 1'b1;
							end
						end
						default: err = 1'b1;
					endcase
				end
				if (err) begin
					rcode = `DPC_RSP_ERR;
					rval  = {16'h0000, fault};
					wr    = 1'b0;
					nv    = 1'b0;
				end
				if (wr) begin
					// Values are stored as raw integers; scaling is the host's.
					mem_we    = 1'b1;
					mem_waddr = param_number[AW-1:0];
					mem_wdata = {mem_rdata[37:32], wval};
				end
				n.nvm_wr     = nv;
				n.nvm_pnu    = param_number;
				n.ctl_word   = s.req_cw;
				n.ref_word   = s.req_ref;
				n.rsp_key    = {rcode, param_number};
				n.rsp_idx    = s.req_idx;
				n.rsp_val    = rval;
				n.rsp_pcd1   = status_word;
				n.rsp_pcd2   = out_freq;
				n.rsp_addr   = s.req_addr;
				n.rsp_len    = (rcode == `DPC_RSP_TEXT) ?
					`DPC_TXT_LEN : s.req_len;
				n.rsp_err    = err;
				n.rsp_bcast  = s.bcast;
				// Set wins over a clear written in the same cycle.
				if (!s.bcast) begin
					n.rsp_rdy = 1'b1;
				end
				n.state = DPC_IDLE;
			end
			default: n.state = DPC_IDLE;
		endcase

		// Read data is captured in the setup phase, shown in the access.
		if (psel && !penable) begin
			n.pslverr = 1'b0;
			case (paddr)
				`DPC_OFF_CFG: n.prdata = {17'h0, s.cfg_stop2, s.cfg_par,
					s.cfg_baud, s.cfg_addr, s.cfg_alt};
				`DPC_OFF_REQ_ADDR: n.prdata = {16'h0, s.req_len, s.req_addr};
				`DPC_OFF_REQ_KEY:  n.prdata = {s.req_idx, s.req_key};
				`DPC_OFF_REQ_VAL:  n.prdata = s.req_val;
				`DPC_OFF_REQ_PCD:  n.prdata = {s.req_ref, s.req_cw};
				`DPC_OFF_GO: n.prdata = {27'h0, s.rsp_miss, s.rsp_bcast,
					s.rsp_err, s.rsp_rdy, busy};
				`DPC_OFF_RSP_KEY:  n.prdata = {s.rsp_idx, s.rsp_key};
				`DPC_OFF_RSP_VAL:  n.prdata = s.rsp_val;
				`DPC_OFF_RSP_PCD:  n.prdata = {s.rsp_pcd2, s.rsp_pcd1};
				`DPC_OFF_RSP_ADDR: n.prdata = {16'h0, s.rsp_len, s.rsp_addr};
				`DPC_OFF_TYPE_SEL: n.prdata = {26'h0, s.type_sel};
				default: begin
					n.prdata  = 32'h0000_0000;
					n.pslverr = !(paddr[11:8] == 4'h1 &&
						int'(paddr[7:2]) < DEPTH);
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n_int) begin
		if (!rst_n_int) begin
			s          <= '0;
			s.state    <= DPC_IDLE;
			s.cfg_addr <= `DPC_RST_ADDR;
			s.cfg_baud <= `DPC_RST_BAUD;
			s.cfg_par  <= `DPC_RST_PARITY;
		end else begin
			s <= n;
		end
	end

	assign pready         = psel && penable;
	assign prdata         = s.prdata;
	assign pslverr        = psel && penable && s.pslverr;
	assign proto_alt      = s.cfg_alt;
	assign baud_sel       = s.cfg_baud;
	assign parity_sel     = s.cfg_par;
	assign two_stop       = s.cfg_stop2;
	assign cw_start       = s.ctl_word[`DPC_CW_START];
	assign cw_coast_stop  = s.ctl_word[`DPC_CW_COAST];
	assign cw_quick_stop  = s.ctl_word[`DPC_CW_QUICK];
	assign cw_dc_brake    = s.ctl_word[`DPC_CW_DCBRAKE];
	assign cw_ramp_stop   = s.ctl_word[`DPC_CW_RAMP];
	assign cw_fault_reset = s.ctl_word[`DPC_CW_FRESET];
	assign cw_preset      = s.ctl_word[`DPC_CW_PRESET_LSB +: 2];
	assign cw_reverse     = s.ctl_word[`DPC_CW_REVERSE];
	assign cw_setup       = s.ctl_word[`DPC_CW_SETUP_LSB +: 2];
	assign cw_relay       = s.ctl_word[`DPC_CW_RELAY];
	assign ref_word       = s.ref_word;
	assign nvm_wr         = s.nvm_wr;
	assign nvm_pnu        = s.nvm_pnu;
	assign nvm_data       = s.rsp_val;

endmodule : dpc_top
`default_nettype wire

// ---- tb/dpc_drive_model.sv ----
// Drive-side model: status and frequency source, non-volatile store sink.
`default_nettype none
module dpc_drive_model (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_b,
	// Store request.
	input  wire logic        nvm_wr,
	input  wire logic [11:0] nvm_pnu,
	input  wire logic [31:0] nvm_data,
	// Drive state and store record.
	output logic      [15:0] status_word,
	output logic      [15:0] out_freq,
	output logic      [7:0]  nvm_count,
	output logic      [43:0] nvm_last
);
	timeunit 1ns;
	timeprecision 1ns;
	// Status moves only with store writes, so it is steady while a request runs.
	assign status_word = {8'hA5, nvm_count};
	assign out_freq    = ~status_word;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			nvm_count <= 8'h00;
			nvm_last  <= 44'h0;
		end else if (nvm_wr) begin
			nvm_count <= nvm_count + 8'h01;
			nvm_last  <= {nvm_pnu, nvm_data};
		end
	end
endmodule : dpc_drive_model
`default_nettype wire

// ---- tb/dpc_top_props.sv ----
// Concurrent checks on the ports of the parameter channel interpreter.
`include "dpc_params.svh"
`default_nettype none
module dpc_top_props #(
	parameter int DEPTH = 64
) (
	// Clock, reset and bus.
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// Line settings.
	input wire logic        proto_alt,
	input wire logic [2:0]  baud_sel,
	input wire logic [1:0]  parity_sel,
	input wire logic        two_stop,
	// Drive commands and store request.
	input wire logic [15:0] ref_word,
	input wire logic        cw_start,
	input wire logic        cw_coast_stop,
	input wire logic        cw_reverse,
	input wire logic        cw_relay,
	input wire logic        nvm_wr,
	input wire logic [11:0] nvm_pnu
);
	logic        go_wr;
	logic        cfg_wr;
	logic [19:0] drv;
	assign go_wr  = psel && penable && pwrite && paddr == `DPC_OFF_GO;
	assign cfg_wr = psel && penable && pwrite && paddr == `DPC_OFF_CFG;
	assign drv    = {cw_start, cw_coast_stop, cw_reverse, cw_relay, ref_word};
	default clocking dck @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access without ready");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	a_line_reset: assert property ($rose(rst_b) |-> baud_sel == 3'h2
		&& parity_sel == 2'h0 && !two_stop && !proto_alt)
		else $error("line settings not at default");
	a_line_cause: assert property (!$stable({proto_alt, baud_sel,
		parity_sel, two_stop}) |-> $past(cfg_wr))
		else $error("line setting moved without write");
	// A drive command may only follow a request started by the host.
	a_drive_cause: assert property (!$stable(drv) |-> $past(go_wr, 2)
		|| $past(go_wr, 3) || $past(go_wr, 4))
		else $error("control word moved without request");
	a_store_pulse: assert property (nvm_wr |=> !nvm_wr)
		else $error("store request longer than one cycle");
	a_store_cause: assert property (nvm_wr |-> $past(go_wr, 2)
		|| $past(go_wr, 3) || $past(go_wr, 4))
		else $error("store request without request");
	a_store_range: assert property (nvm_wr |-> nvm_pnu < DEPTH)
		else $error("store of missing parameter");
	c_store: cover property (nvm_wr);
	c_slverr: cover property (pslverr);
	c_drive: cover property (!$stable(drv));
endmodule : dpc_top_props
bind dpc_top dpc_top_props #(.DEPTH(DEPTH)) u_props (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.proto_alt(proto_alt), .baud_sel(baud_sel), .parity_sel(parity_sel),
	.two_stop(two_stop), .ref_word(ref_word), .cw_start(cw_start),
	.cw_coast_stop(cw_coast_stop), .cw_reverse(cw_reverse),
	.cw_relay(cw_relay), .nvm_wr(nvm_wr), .nvm_pnu(nvm_pnu)
);
`default_nettype wire

// ---- tb/dpc_top_tb.sv ----
// Self-checking bench for the parameter channel interpreter.
`include "dpc_params.svh"
`default_nettype none
module dpc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata, nvm_data;
	wire         pready, pslverr, proto_alt, two_stop, nvm_wr;
	wire  [15:0] status_word, out_freq, ref_word;
	wire  [2:0]  baud_sel;
	wire  [1:0]  parity_sel;
	wire  [11:0] cw, nvm_pnu;
	wire  [7:0]  nvm_count;
	wire  [43:0] nvm_last;
	int          n_errors = 0;
	int          n_compared = 0;
	int          i;
	integer      seed = 44860;
	logic [64:0] q[$];
	logic [64:0] ent;
	logic [31:0] rd, process_words;
	logic [27:0] hold;
	logic [5:0]  tys[9] = '{`DPC_TY_I16, `DPC_TY_I32, `DPC_TY_U8,
		`DPC_TY_U16, `DPC_TY_U32, `DPC_TY_BYTES, `DPC_TY_TDIFF,
		`DPC_TY_RSVD, `DPC_TY_BITS};
	logic [3:0]  cds[9] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h7,
		4'h1};
	always #25 clock = ~clock;
	dpc_top #(.DEPTH(64)) uut (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .status_word(status_word),
		.out_freq(out_freq), .proto_alt(proto_alt), .baud_sel(baud_sel),
		.parity_sel(parity_sel), .two_stop(two_stop), .cw_start(cw[0]),
		.cw_coast_stop(cw[1]), .cw_quick_stop(cw[2]), .cw_dc_brake(cw[3]),
		.cw_ramp_stop(cw[4]), .cw_fault_reset(cw[5]), .cw_preset(cw[7:6]),
		.cw_reverse(cw[8]), .cw_setup(cw[10:9]), .cw_relay(cw[11]),
		.ref_word(ref_word), .nvm_wr(nvm_wr), .nvm_pnu(nvm_pnu),
		.nvm_data(nvm_data)
	);
	dpc_drive_model u_drive (
		.clock(clock), .rst_b(rst_b), .nvm_wr(nvm_wr), .nvm_pnu(nvm_pnu),
		.nvm_data(nvm_data), .status_word(status_word), .out_freq(out_freq),
		.nvm_count(nvm_count), .nvm_last(nvm_last)
	);
	task automatic fail(input string m);
		n_errors++;
		$display("CHECK FAILED t=%0t %s", $time, m);
	endtask : fail
	task automatic final_report;
		$display("errors %0d of %0d compared", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (!ok)
			fail(m);
	endtask : chk
	// Each access notes its expected answer; the monitor below judges it.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic e, input logic [31:0] m,
		input logic [31:0] x);
		q.push_back({e, m, x});
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			fail("bus hang");
			final_report();
		end
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0, 1'b0, m, x);
	endtask : rdc
	task automatic run(input logic [7:0] ad, input logic [15:0] key,
		input logic [15:0] idx, input logic [31:0] val);
		process_words = $random(seed);
		wr(`DPC_OFF_REQ_ADDR, {16'h0, 8'h10, ad});
		wr(`DPC_OFF_REQ_KEY, {idx, key});
		wr(`DPC_OFF_REQ_VAL, val);
		wr(`DPC_OFF_REQ_PCD, process_words);
		wr(`DPC_OFF_GO, 32'h2);
		wr(`DPC_OFF_GO, 32'h1);
		for (int k = 0; k < 20; k++) begin
			rdc(`DPC_OFF_GO, 32'h0, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		if (rd[0] !== 1'b0) begin
			fail("request hang");
			final_report();
		end
	endtask : run
	task automatic rsp(input logic [3:0] c, input logic [31:0] m,
		input logic [31:0] v, input logic [3:0] s);
		rdc(`DPC_OFF_GO, 32'h1E, {27'h0, s, 1'b0});
		rdc(`DPC_OFF_RSP_KEY, 32'hF000, {16'h0, c, 12'h0});
		rdc(`DPC_OFF_RSP_VAL, m, v);
	endtask : rsp
	always @(posedge clock) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			ent = q.pop_front();
			n_compared++;
			if (pslverr !== ent[64] || (prdata & ent[63:32]) !==
				(ent[31:0] & ent[63:32]))
				fail("bus answer");
		end
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		rdc(`DPC_OFF_CFG, '1, 32'h0000_0402);
		apb(1'b0, 12'h0FC, 32'h0, 1'b1, 32'h0, 32'h0);
		apb(1'b1, 12'h0F8, 32'h0, 1'b1, 32'h0, 32'h0);
		wr(`DPC_OFF_TYPE_SEL, 32'h6);
		wr(`DPC_OFF_MEM_BASE + 12'h014, 32'h0000_1234);
		wr(`DPC_OFF_TYPE_SEL, 32'h9);
		wr(`DPC_OFF_MEM_BASE + 12'h018, 32'h0);
		run(8'h81, 16'h1005, 16'h0400, 32'h0);
		rsp(4'h1, '1, 32'h1234, 4'h1);
		rdc(`DPC_OFF_RSP_KEY, 32'hFFFF, 32'h1005);
		rdc(`DPC_OFF_RSP_PCD, '1, {out_freq, status_word});
		rdc(`DPC_OFF_RSP_ADDR, 32'hFFFF, 32'h1081);
		chk({cw, ref_word} === {process_words[11:0], process_words[31:16]}, "control");
		run(8'h81, 16'hE005, 16'h0, 32'h0000_03E8);
		chk({nvm_count, nvm_last[43:32], nvm_last[15:0]} ===
			{8'h01, 12'h005, 16'h03E8}, "store word");
		run(8'h81, 16'h1005, 16'h0, 32'h0);
		rsp(4'h1, '1, 32'h03E8, 4'h1);
		run(8'h81, 16'h2005, 16'h0, 32'h7);
		chk(nvm_count === 8'h01, "working memory only");
		run(8'h81, 16'h1005, 16'h0001, 32'h0);
		rsp(4'h7, 32'hFFFF, 32'h3, 4'h3);
		run(8'h81, 16'h1040, 16'h0, 32'h0);
		rsp(4'h7, 32'hFFFF, 32'h0, 4'h3);
		run(8'h81, 16'h5005, 16'h0, 32'h0);
		rsp(4'h7, 32'hFFFF, 32'h5, 4'h3);
		run(8'h81, 16'h0005, 16'h0, 32'h0);
		rsp(4'h0, '1, 32'h0, 4'h1);
		run(8'h81, 16'hF005, 16'h0400, 32'h0);
		rsp(4'h7, 32'hFFFF, 32'h5, 4'h3);
		run(8'h81, 16'hF006, 16'h0400, 32'h0);
		rsp(4'hF, 32'h0, 32'h0, 4'h1);
		rdc(`DPC_OFF_RSP_ADDR, 32'hFF00, 32'h0E00);
		run(8'h81, 16'hF006, 16'h0500, 32'h4142_4344);
		rsp(4'hF, 32'h0, 32'h0, 4'h1);
		for (i = 0; i < 9; i++) begin
			wr(`DPC_OFF_TYPE_SEL, {26'h0, tys[i]});
			wr(`DPC_OFF_MEM_BASE + 12'h01C, 32'hCAFE_1234);
			run(8'h81, 16'h1007, 16'h0, 32'h0);
			rsp(cds[i], cds[i] == 4'h7 ? 32'hFFFF : '1, cds[i] == 4'h2 ?
				32'hCAFE_1234 : cds[i] == 4'h1 ? 32'h1234 : 32'h5,
				cds[i] == 4'h7 ? 4'h3 : 4'h1);
		end
		run(8'h81, 16'h3007, 16'h0, 32'h1);
		rsp(4'h7, 32'hFFFF, 32'h5, 4'h3);
		wr(`DPC_OFF_TYPE_SEL, 32'h7);
		// The type travels with each memory load, so reload parameter 7.
		wr(`DPC_OFF_MEM_BASE + 12'h01C, 32'h0);
		run(8'h81, 16'hD007, 16'h0, 32'h89AB_CDEF);
		chk({nvm_count, nvm_last} === {8'h02, 12'h007, 32'h89AB_CDEF},
			"store double");
		run(8'h81, 16'h1007, 16'h0, 32'h0);
		rsp(4'h2, '1, 32'h89AB_CDEF, 4'h1);
		run(8'h80, 16'h1005, 16'h0, 32'h0);
		rdc(`DPC_OFF_GO, 32'h1E, 32'h8);
		chk({cw, ref_word} === {process_words[11:0], process_words[31:16]}, "broadcast");
		hold = {cw, ref_word};
		run(8'h82, 16'h1005, 16'h0, 32'h0);
		// A miss leaves the broadcast flag of the last executed request.
		rdc(`DPC_OFF_GO, 32'h1E, 32'h18);
		chk({cw, ref_word} === hold, "other address");
		wr(`DPC_OFF_CFG, 32'h0000_05EF);
		wr(`DPC_OFF_CFG, 32'h0000_75F1);
		rdc(`DPC_OFF_CFG, '1, 32'h0000_75EF);
		chk({proto_alt, parity_sel, two_stop} === 4'hF, "line");
		for (i = 0; i < 7; i++) begin
			wr(`DPC_OFF_CFG, 32'h0000_01EF | (i << 9));
			@(negedge clock);
			chk(baud_sel === i[2:0], "baud select");
		end
		run(8'hF7, 16'h1005, 16'h0, 32'h0);
		rsp(4'h1, '1, 32'h7, 4'h1);
		run(8'h00, 16'h1005, 16'h0, 32'h0);
		rdc(`DPC_OFF_GO, 32'h1E, 32'h8);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		rdc(`DPC_OFF_CFG, '1, 32'h0000_0402);
		final_report();
	end
endmodule : dpc_top_tb
`default_nettype wire
